// ---- rtl/lmprm_pkg.sv ----
/*
 * lmprm_pkg: constants and types of the paged LED matrix register bank.
 * Assumes a byte-wide register access port decoded by a serial front end.
 */
package lmprm_pkg;
   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int NUM_ROWS = 4;
   localparam int NUM_SINKS = 24;
   localparam int NUM_OPEN = 23;
   // ---------------------------------------------------------------
   // offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_SINK_FIRST = 8'h02;
   localparam logic [7:0] OFS_SINK_LAST = 8'h30;
   localparam logic [7:0] OFS_ALL_SEL = 8'h40;
   localparam logic [7:0] OFS_SPECIAL = 8'h60;
   localparam logic [7:0] OFS_CFG = 8'h02;
   localparam logic [7:0] OFS_GCC_R = 8'h04;
   localparam logic [7:0] OFS_GCC_G = 8'h06;
   localparam logic [7:0] OFS_GCC_B = 8'h08;
   localparam logic [7:0] OFS_SPREAD = 8'h0a;
   localparam logic [7:0] OFS_EDGE = 8'h0e;
   localparam logic [7:0] OFS_THERM = 8'h10;
   localparam logic [7:0] OFS_OPEN_FIRST = 8'h12;
   localparam logic [7:0] OFS_OPEN_LAST = 8'h28;
   localparam logic [7:0] OFS_PD_A = 8'h30;
   localparam logic [7:0] OFS_PD_B = 8'h32;
   localparam logic [7:0] OFS_PU_A = 8'h34;
   localparam logic [7:0] OFS_PU_B = 8'h36;
   localparam logic [7:0] OFS_SOFT_RST = 8'h3e;
   localparam logic [7:0] OFS_FAULT = 8'h78;
   localparam logic [7:0] OFS_PAGE = 8'h7a;
   localparam logic [7:0] OFS_LOCK = 8'h7e;
   localparam logic [7:0] OFS_UPDATE = 8'h81;
   // ---------------------------------------------------------------
   // page codes, key values and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] PAGE_DUTY0 = 8'h56;
   localparam logic [7:0] PAGE_SCALE0 = 8'h66;
   localparam logic [7:0] PAGE_FUNC = 8'h6e;
   localparam logic [7:0] UNLOCK_KEY = 8'hc6;
   localparam logic [7:0] UPDATE_KEY = 8'h00;
   localparam logic [7:0] RST_DUTY = 8'h00;
   localparam logic [7:0] RST_SCALE = 8'hfe;
   localparam logic [7:0] RST_CFG = 8'h02;
   localparam logic [7:0] RST_GCC = 8'hfe;
   localparam logic [7:0] RST_EDGE = 8'h90;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] LSB_CLEAR = 8'hfe;
   // ---------------------------------------------------------------
   // host bus in use
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      LMPRM_BUS_FAST = 2'h0,
      LMPRM_BUS_CHAIN = 2'h1,
      LMPRM_BUS_SPI = 2'h2,
      LMPRM_BUS_I2C = 2'h3
   } lmprm_bus_t;
   // register access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] data;
   } lmprm_req_t;
   // function page settings
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] gcc_r;
      logic [7:0] gcc_g;
      logic [7:0] gcc_b;
      logic [7:0] spread;
      logic [7:0] edge_spread;
      logic [7:0] thermal;
      logic [7:0] pd_a;
      logic [7:0] pd_b;
      logic [7:0] pu_a;
      logic [7:0] pu_b;
   } lmprm_func_t;
endpackage

// ---- rtl/lmprm_regbank.sv ----
/*
 * lmprm_regbank: paged register bank of a four-row, 24-sink LED matrix
 * driver: duty pages, dot-correction scale pages and a function page.
 * Assumes a serial front end that hands over one decoded byte access per
 * cycle on req_i, synchronous to sys_clk_i, and names the bus in use.
 */
//
// Overview of operation
// - duty byte per sink, offsets 02h..30h
// - proprietary buses: duty seven bits, bit0 zero
// - spi/i2c: full eight-bit duty value
// - duty special mode only on proprietary buses
// - scale byte per sink, default FE
// - scale special mode only on proprietary buses
// - spi/i2c: full eight-bit scale value
// - three global currents 04h/06h/08h, reset FE
// - spread spectrum register 0Ah, reset zero
// - edge spreading register 0Eh, reset 90h
// - thermal roll-off register 10h, reset zero
// - open results readable at 12h..28h
// - row pull-down selectors at 30h, 32h
// - sink pull-up selectors at 34h, 36h
// - write to 3Eh resets the device
// - fault state readable at 78h
// - page select at 7Ah, default 56h
// - spi/i2c duty applied on 00h to 81h
`timescale 1ns/100ps
`default_nettype none
module lmprm_regbank #(
   parameter int ROWS = lmprm_pkg::NUM_ROWS,
   parameter int SINKS = lmprm_pkg::NUM_SINKS,
   parameter int OPENS = lmprm_pkg::NUM_OPEN
) (
   // clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // register access
   input wire lmprm_pkg::lmprm_bus_t bus_i,
   input wire lmprm_pkg::lmprm_req_t req_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   // status from the analog side
   input wire logic [OPENS*8-1:0] open_data_i,
   input wire logic open_load_i,
   input wire logic [7:0] fault_i,
   // settings to the matrix engine
   output logic [ROWS-1:0][SINKS-1:0][7:0] duty_o,
   output logic [ROWS-1:0][SINKS-1:0][7:0] scale_o,
   output logic [ROWS-1:0][7:0] duty_special_o,
   output logic [ROWS-1:0][7:0] scale_special_o,
   output logic [2*ROWS-1:0][7:0] all_sel_o,
   output lmprm_pkg::lmprm_func_t func_o,
   output logic [7:0] page_o,
   output logic soft_reset_o
);
   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   // sink index of an offset, SINKS when not a sink offset
   function automatic logic [5:0] sink_of(input logic [7:0] a);
      logic [5:0] r;
      r = 6'(SINKS);
      if (!a[0] && a >= lmprm_pkg::OFS_SINK_FIRST && a <= lmprm_pkg::OFS_SINK_LAST) begin
         r = 6'(a[7:1] - 7'h01);
      end
      return r;
   endfunction

   // page kind: bit4 duty, bit5 scale, low bits the row
   function automatic logic [5:0] kind_of(input logic [7:0] p);
      logic [5:0] r;
      r = 6'h00;
      for (int k = 0; k < ROWS; k++) begin
         if (p == lmprm_pkg::PAGE_DUTY0 + 8'(2*k)) begin
            r = 6'h10 | 6'(k);
         end
         if (p == lmprm_pkg::PAGE_SCALE0 + 8'(2*k)) begin
            r = 6'h20 | 6'(k);
         end
      end
      return r;
   endfunction

   // 7-bit buses drop bit0, the others keep all eight bits
   function automatic logic [7:0] fit(input logic [7:0] v, input logic prop);
      return prop ? (v & lmprm_pkg::LSB_CLEAR) : v;
   endfunction

   // ---------------------------------------------------------------
   // common terms
   // ---------------------------------------------------------------
   logic [7:0] page_ff;
   logic unlock_ff;
   logic soft_rst_ff;
   logic rst;
   logic prop;
   logic wr;
   logic [5:0] kind;
   logic [5:0] sidx;
   logic on_duty;
   logic on_scale;
   logic on_func;
   logic [1:0] row;
   logic page_ok;
   logic [ROWS-1:0][SINKS-1:0][7:0] duty_shadow_ff;
   logic [ROWS-1:0][SINKS-1:0][7:0] scale_ff;
   logic [ROWS-1:0][7:0] dspec_ff;
   logic [ROWS-1:0][7:0] sspec_ff;
   lmprm_pkg::lmprm_func_t func_ff;
   logic [OPENS-1:0][7:0] open_ff;
   logic [7:0] fault_ff;

   // soft reset acts one cycle after its write, like a hard reset
   assign rst = reset_i | soft_rst_ff;
   assign prop = (bus_i == lmprm_pkg::LMPRM_BUS_FAST) || (bus_i == lmprm_pkg::LMPRM_BUS_CHAIN);
   assign wr = ce_i & req_i.wr;
   assign kind = kind_of(page_ff);
   assign sidx = sink_of(req_i.addr);
   assign on_duty = kind[4];
   assign on_scale = kind[5];
   assign on_func = (page_ff == lmprm_pkg::PAGE_FUNC);
   assign row = kind[1:0];
   // page writes pass when unlocked, always on spi; bad codes dropped
   assign page_ok = (unlock_ff || bus_i == lmprm_pkg::LMPRM_BUS_SPI) &&
                    (kind_of(req_i.data) != 6'h00 || req_i.data == lmprm_pkg::PAGE_FUNC);

   // ---------------------------------------------------------------
   // paging and lock
   // ---------------------------------------------------------------
   // page pointer, outside every page
   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         page_ff <= lmprm_pkg::PAGE_DUTY0;
      end else if (wr && req_i.addr == lmprm_pkg::OFS_PAGE && page_ok) begin
         page_ff <= req_i.data;
      end
   end

   // the key opens one page write only
   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         unlock_ff <= 1'b0;
      end else if (wr && req_i.addr == lmprm_pkg::OFS_LOCK) begin
         unlock_ff <= (req_i.data == lmprm_pkg::UNLOCK_KEY);
      end else if (wr && req_i.addr == lmprm_pkg::OFS_PAGE) begin
         unlock_ff <= 1'b0;
      end
   end

   // software reset pulse, cleared by the next enabled edge; only reset_i resets it
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         soft_rst_ff <= 1'b0;
      end else if (ce_i) begin
         soft_rst_ff <= wr && on_func && req_i.addr == lmprm_pkg::OFS_SOFT_RST;
      end
   end

   // ---------------------------------------------------------------
   // duty and scale pages
   // ---------------------------------------------------------------
   // only the selected row's byte is touched; others keep their value
   for (genvar r = 0; r < ROWS; r++) begin : g_row
      for (genvar s = 0; s < SINKS; s++) begin : g_sink
         always_ff @(posedge sys_clk_i) begin
            if (rst) begin
               duty_shadow_ff[r][s] <= lmprm_pkg::RST_DUTY;
            end else if (wr && on_duty && row == 2'(r) && sidx == 6'(s)) begin
               duty_shadow_ff[r][s] <= req_i.data;
            end
         end
         always_ff @(posedge sys_clk_i) begin
            if (rst) begin
               scale_ff[r][s] <= lmprm_pkg::RST_SCALE;
            end else if (wr && on_scale && row == 2'(r) && sidx == 6'(s)) begin
               scale_ff[r][s] <= req_i.data;
            end
         end
         // applied duty: live on 7-bit buses, on update on 8-bit ones
         always_ff @(posedge sys_clk_i) begin
            if (rst) begin
               duty_o[r][s] <= lmprm_pkg::RST_DUTY;
            end else if (ce_i && prop) begin
               duty_o[r][s] <= fit(duty_shadow_ff[r][s], 1'b1);
            end else if (wr && req_i.addr == lmprm_pkg::OFS_UPDATE &&
                         req_i.data == lmprm_pkg::UPDATE_KEY) begin
               duty_o[r][s] <= duty_shadow_ff[r][s];
            end
         end
         // applied scale follows the bus width of the moment
         always_ff @(posedge sys_clk_i) begin
            if (rst) begin
               scale_o[r][s] <= lmprm_pkg::RST_SCALE;
            end else if (ce_i) begin
               scale_o[r][s] <= fit(scale_ff[r][s], prop);
            end
         end
      end
      // per-page all-channel select and special mode
      always_ff @(posedge sys_clk_i) begin
         if (rst) begin
            all_sel_o[r] <= lmprm_pkg::RST_ZERO;
            all_sel_o[r+ROWS] <= lmprm_pkg::RST_ZERO;
            dspec_ff[r] <= lmprm_pkg::RST_ZERO;
            sspec_ff[r] <= lmprm_pkg::RST_ZERO;
         end else if (wr && row == 2'(r)) begin
            if (on_duty && req_i.addr == lmprm_pkg::OFS_ALL_SEL) begin
               all_sel_o[r] <= req_i.data;
            end
            if (on_scale && req_i.addr == lmprm_pkg::OFS_ALL_SEL) begin
               all_sel_o[r+ROWS] <= req_i.data;
            end
            if (on_duty && req_i.addr == lmprm_pkg::OFS_SPECIAL) begin
               dspec_ff[r] <= req_i.data;
            end
            if (on_scale && req_i.addr == lmprm_pkg::OFS_SPECIAL) begin
               sspec_ff[r] <= req_i.data;
            end
         end
      end
      // special modes read as normal unless a 7-bit bus is in use
      always_ff @(posedge sys_clk_i) begin
         if (rst) begin
            duty_special_o[r] <= lmprm_pkg::RST_ZERO;
            scale_special_o[r] <= lmprm_pkg::RST_ZERO;
         end else if (ce_i) begin
            duty_special_o[r] <= prop ? dspec_ff[r] : lmprm_pkg::RST_ZERO;
            scale_special_o[r] <= prop ? sspec_ff[r] : lmprm_pkg::RST_ZERO;
         end
      end
   end

   // ---------------------------------------------------------------
   // function page
   // ---------------------------------------------------------------
   // write-only settings
   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         func_ff.cfg <= lmprm_pkg::RST_CFG;
         func_ff.gcc_r <= lmprm_pkg::RST_GCC;
         func_ff.gcc_g <= lmprm_pkg::RST_GCC;
         func_ff.gcc_b <= lmprm_pkg::RST_GCC;
         func_ff.spread <= lmprm_pkg::RST_ZERO;
         func_ff.edge_spread <= lmprm_pkg::RST_EDGE;
         func_ff.thermal <= lmprm_pkg::RST_ZERO;
         func_ff.pd_a <= lmprm_pkg::RST_ZERO;
         func_ff.pd_b <= lmprm_pkg::RST_ZERO;
         func_ff.pu_a <= lmprm_pkg::RST_ZERO;
         func_ff.pu_b <= lmprm_pkg::RST_ZERO;
      end else if (wr && on_func) begin
         case (req_i.addr)
            lmprm_pkg::OFS_CFG: func_ff.cfg <= req_i.data;
            lmprm_pkg::OFS_GCC_R: func_ff.gcc_r <= req_i.data;
            lmprm_pkg::OFS_GCC_G: func_ff.gcc_g <= req_i.data;
            lmprm_pkg::OFS_GCC_B: func_ff.gcc_b <= req_i.data;
            lmprm_pkg::OFS_SPREAD: func_ff.spread <= req_i.data;
            lmprm_pkg::OFS_EDGE: func_ff.edge_spread <= req_i.data;
            lmprm_pkg::OFS_THERM: func_ff.thermal <= req_i.data;
            lmprm_pkg::OFS_PD_A: func_ff.pd_a <= req_i.data;
            lmprm_pkg::OFS_PD_B: func_ff.pd_b <= req_i.data;
            lmprm_pkg::OFS_PU_A: func_ff.pu_a <= req_i.data;
            lmprm_pkg::OFS_PU_B: func_ff.pu_b <= req_i.data;
            default: begin
            end
         endcase
      end
   end

   // outputs; global currents narrowed like the scale bytes
   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         func_o <= '0;
         func_o.cfg <= lmprm_pkg::RST_CFG;
         func_o.gcc_r <= lmprm_pkg::RST_GCC;
         func_o.gcc_g <= lmprm_pkg::RST_GCC;
         func_o.gcc_b <= lmprm_pkg::RST_GCC;
         func_o.edge_spread <= lmprm_pkg::RST_EDGE;
      end else if (ce_i) begin
         func_o <= func_ff;
         func_o.gcc_r <= fit(func_ff.gcc_r, prop);
         func_o.gcc_g <= fit(func_ff.gcc_g, prop);
         func_o.gcc_b <= fit(func_ff.gcc_b, prop);
      end
   end

   // status captured from the analog side
   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         open_ff <= '0;
         fault_ff <= lmprm_pkg::RST_ZERO;
      end else if (ce_i) begin
         fault_ff <= fault_i;
         if (open_load_i) begin
            open_ff <= open_data_i;
         end
      end
   end

   // read port: write-only and unmapped offsets answer zero
   always_ff @(posedge sys_clk_i) begin
      if (rst) begin
         rdata_o <= lmprm_pkg::RST_ZERO;
         rvalid_o <= 1'b0;
      end else if (ce_i) begin
         rvalid_o <= req_i.rd;
         rdata_o <= lmprm_pkg::RST_ZERO;
         if (req_i.rd && on_func) begin
            if (req_i.addr >= lmprm_pkg::OFS_OPEN_FIRST &&
                req_i.addr <= lmprm_pkg::OFS_OPEN_LAST) begin
               rdata_o <= open_ff[5'(req_i.addr - lmprm_pkg::OFS_OPEN_FIRST)];
            end else if (req_i.addr == lmprm_pkg::OFS_FAULT) begin
               rdata_o <= fault_ff;
            end
         end
      end
   end

   assign page_o = page_ff;
   assign soft_reset_o = soft_rst_ff;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst);

   AST_PAGE_LOCKED: assert property (
      (wr && req_i.addr == lmprm_pkg::OFS_PAGE && !unlock_ff &&
       bus_i != lmprm_pkg::LMPRM_BUS_SPI) |=> $stable(page_ff))
      else $error("page changed without unlock");
   AST_PAGE_TAKEN: assert property (
      (wr && req_i.addr == lmprm_pkg::OFS_PAGE && page_ok) |=> page_ff == $past(req_i.data))
      else $error("page select not taken");
   AST_DUTY_LIVE: assert property (
      (ce_i && prop) [*2] |-> duty_o[0][0][0] == 1'b0)
      else $error("duty bit0 set on a 7-bit bus");
   AST_DUTY_HELD: assert property (
      (!prop && !(wr && req_i.addr == lmprm_pkg::OFS_UPDATE)) |=> $stable(duty_o))
      else $error("duty applied without update");
   AST_DUTY_UPDATE: assert property (
      (ce_i && !prop && req_i.wr && req_i.addr == lmprm_pkg::OFS_UPDATE &&
       req_i.data == lmprm_pkg::UPDATE_KEY) |=> duty_o == $past(duty_shadow_ff))
      else $error("update did not apply duty");
   AST_SCALE_ROUTE: assert property (
      (wr && on_scale && row == 2'd0 && sidx == 6'd0) |=> $stable(scale_ff[1][0]))
      else $error("scale write leaked to another row");
   AST_SCALE_FULL: assert property (
      (ce_i && !prop) [*2] |-> scale_o[0][0] == $past(scale_ff[0][0]))
      else $error("scale narrowed on an 8-bit bus");
   AST_SPECIAL_GATED: assert property (
      (ce_i && !prop) |=> duty_special_o == '0 && scale_special_o == '0)
      else $error("special mode active on an 8-bit bus");
   AST_SOFT_RESET: assert property (disable iff (reset_i)
      (wr && on_func && req_i.addr == lmprm_pkg::OFS_SOFT_RST) |=> soft_rst_ff)
      else $error("soft reset not triggered");
   AST_FAULT_READ: assert property (
      (ce_i && req_i.rd && on_func && req_i.addr == lmprm_pkg::OFS_FAULT) |=>
      rvalid_o && rdata_o == $past(fault_ff))
      else $error("fault read wrong");
   AST_EDGE_KEPT: assert property (
      (wr && req_i.addr == lmprm_pkg::OFS_PAGE) |=> $stable(func_ff))
      else $error("function page lost on page change");

   COV_PAGE_FUNC: cover property (unlock_ff ##1 on_func);
   COV_SPI_UPDATE: cover property (wr && !prop && req_i.addr == lmprm_pkg::OFS_UPDATE);
   COV_SOFT_RST: cover property (wr && on_func && req_i.addr == lmprm_pkg::OFS_SOFT_RST);
   COV_OPEN_READ: cover property (req_i.rd && on_func && req_i.addr == lmprm_pkg::OFS_OPEN_LAST);
endmodule
`default_nettype wire

// ---- verification/lmprm_host.sv ----
/*
 * lmprm_host: host controller model issuing byte accesses to the bank.
 * Assumes the bench calls its tasks and shares sys_clk_i with the bank.
 */
`timescale 1ns/100ps
`default_nettype none
module lmprm_host (
   // clock
   input wire logic sys_clk_i,
   // request to the bank
   output var lmprm_pkg::lmprm_req_t req_o
);
   // ---------------------------------------------------------------
   // byte accesses
   // ---------------------------------------------------------------
   // idle bus: no strobe, no leftover address or data
   initial begin
      req_o = '0;
   end
   // launched just after an edge, held through the sampling edge
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      #1;
      req_o = {w, ~w, a, d};
      @(posedge sys_clk_i);
      #1;
      req_o = '0;
   endtask
   // page change; the spi command carries its page, so no unlock there
   task automatic page(input lmprm_pkg::lmprm_bus_t b, input logic [7:0] code);
      if (b != lmprm_pkg::LMPRM_BUS_SPI) begin
         access(1'b1, lmprm_pkg::OFS_LOCK, lmprm_pkg::UNLOCK_KEY);
      end
      access(1'b1, lmprm_pkg::OFS_PAGE, code);
   endtask
endmodule
`default_nettype wire

// ---- verification/led_matrix_paged_register_map_bench.sv ----
/*
 * led_matrix_paged_register_map_bench: self-checking bench of the bank.
 * Assumes lmprm_pkg is compiled first and lmprm_host drives req_i.
 */
`timescale 1ns/100ps
`default_nettype none
module led_matrix_paged_register_map_bench;
   logic sys_clk_i, reset_i, ce_i, open_load_i, rvalid_o, soft_reset_o;
   lmprm_pkg::lmprm_bus_t bus_i;
   lmprm_pkg::lmprm_req_t req_i;
   logic [7:0] rdata_o, fault_i, page_o;
   logic [23*8-1:0] open_data_i;
   logic [3:0][23:0][7:0] duty_o, scale_o;
   logic [3:0][7:0] duty_special_o, scale_special_o;
   logic [7:0][7:0] all_sel_o;
   lmprm_pkg::lmprm_func_t func_o, fexp;
   int fails, cmp_count;
   // ---------------------------------------------------------------
   // clock and instances
   // ---------------------------------------------------------------
   initial sys_clk_i = 1'b0;
   always #5 sys_clk_i = ~sys_clk_i;
   lmprm_host lmprm_host_i (.sys_clk_i(sys_clk_i), .req_o(req_i));
   lmprm_regbank lmprm_regbank_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .ce_i(ce_i),
      .bus_i(bus_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
      .open_data_i(open_data_i), .open_load_i(open_load_i), .fault_i(fault_i),
      .duty_o(duty_o), .scale_o(scale_o), .duty_special_o(duty_special_o),
      .scale_special_o(scale_special_o), .all_sel_o(all_sel_o), .func_o(func_o),
      .page_o(page_o), .soft_reset_o(soft_reset_o));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // lands just after the n-th edge from now
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      lmprm_host_i.access(1'b1, a, d);
   endtask
   // read answer stands only in the cycle after the sampling edge
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      lmprm_host_i.access(1'b0, a, 8'h00);
      chk({7'h00, rvalid_o}, 8'h01, "read valid");
      chk(rdata_o, e, "read data");
   endtask
   task automatic chk_func(input lmprm_pkg::lmprm_func_t e);
      for (int k = 0; k < 11; k++) begin
         chk(func_o[8*k +: 8], e[8*k +: 8], "function setting");
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk(page_o, 8'h56, "default page");
      chk(duty_o[2][5], 8'h00, "duty reset");
      chk(scale_o[3][23], 8'hfe, "scale reset");
      fexp = {8'h02, 8'hfe, 8'hfe, 8'hfe, 8'h00, 8'h90, 8'h00, 32'h0};
      chk_func(fexp);
   endtask
   // proprietary bus: bit0 dropped, pages kept apart
   task automatic t_duty();
      wr(8'h02, 8'hff);
      wr(8'h30, 8'h81);
      tick(2);
      chk(duty_o[0][0], 8'hfe, "first sink duty");
      chk(duty_o[0][23], 8'h80, "last sink duty");
      lmprm_host_i.page(bus_i, 8'h5c);
      wr(8'h02, 8'h44);
      tick(2);
      chk(duty_o[3][0], 8'h44, "row3 duty");
      chk(duty_o[0][0], 8'hfe, "row0 kept");
      wr(lmprm_pkg::OFS_PAGE, 8'h66);
      tick(1);
      chk(page_o, 8'h5c, "locked page");
   endtask
   // spi: full byte, applied only by the update write
   task automatic t_spi();
      bus_i = lmprm_pkg::LMPRM_BUS_SPI;
      lmprm_host_i.page(bus_i, 8'h56);
      chk(page_o, 8'h56, "spi page");
      wr(8'h02, 8'hff);
      tick(2);
      chk(duty_o[0][0], 8'hfe, "held duty");
      wr(lmprm_pkg::OFS_UPDATE, 8'h00);
      tick(1);
      chk(duty_o[0][0], 8'hff, "updated duty");
      // a frozen bank ignores both the write and the update
      ce_i = 1'b0;
      wr(8'h02, 8'h10);
      wr(lmprm_pkg::OFS_UPDATE, 8'h00);
      ce_i = 1'b1;
      tick(1);
      chk(duty_o[0][0], 8'hff, "frozen duty");
   endtask
   task automatic t_scale();
      lmprm_host_i.page(bus_i, 8'h66);
      wr(8'h02, 8'hff);
      tick(2);
      chk(scale_o[0][0], 8'hff, "spi scale");
      bus_i = lmprm_pkg::LMPRM_BUS_CHAIN;
      wr(lmprm_pkg::OFS_SPECIAL, 8'h04);
      wr(lmprm_pkg::OFS_ALL_SEL, 8'h5a);
      tick(2);
      chk(scale_o[0][0], 8'hfe, "chain scale");
      chk(all_sel_o[4], 8'h5a, "scale all select");
      chk(all_sel_o[0], 8'h00, "duty all select");
      chk(scale_special_o[0], 8'h04, "scale special");
      lmprm_host_i.page(bus_i, 8'h56);
      wr(lmprm_pkg::OFS_SPECIAL, 8'h06);
      tick(2);
      chk(duty_special_o[0], 8'h06, "duty special");
      bus_i = lmprm_pkg::LMPRM_BUS_I2C;
      tick(2);
      chk(duty_special_o[0], 8'h00, "special off");
      chk(scale_special_o[0], 8'h00, "scale special off");
   endtask
   // function page writes, reads and soft reset
   task automatic t_func();
      logic [7:0] ofs [10] = '{8'h04, 8'h06, 8'h08, 8'h0a, 8'h0e, 8'h10,
                              8'h30, 8'h32, 8'h34, 8'h36};
      logic [7:0] val [10] = '{8'hff, 8'h81, 8'h13, 8'h2a, 8'h5c, 8'h30,
                              8'h11, 8'h22, 8'h33, 8'h44};
      lmprm_host_i.page(bus_i, 8'h6e);
      rd(lmprm_pkg::OFS_FAULT, 8'h00);
      for (int k = 0; k < 10; k++) begin
         wr(ofs[k], val[k]);
      end
      tick(2);
      fexp = {8'h02, 8'hff, 8'h81, 8'h13, 8'h2a, 8'h5c, 8'h30, 32'h11223344};
      chk_func(fexp);
      bus_i = lmprm_pkg::LMPRM_BUS_FAST;
      tick(2);
      chk(func_o.gcc_g, 8'h80, "masked green");
      fault_i = 8'h5a;
      open_data_i = '0;
      open_data_i[7:0] = 8'ha5;
      open_data_i[183:176] = 8'h3c;
      open_load_i = 1'b1;
      tick(1);
      open_load_i = 1'b0;
      rd(lmprm_pkg::OFS_FAULT, 8'h5a);
      rd(8'h12, 8'ha5);
      rd(8'h28, 8'h3c);
      rd(8'h04, 8'h00);
      wr(lmprm_pkg::OFS_SOFT_RST, 8'h01);
      chk({7'h00, soft_reset_o}, 8'h01, "soft reset pulse");
      tick(1);
      chk(page_o, 8'h56, "page after soft reset");
      chk(func_o.gcc_g, 8'hfe, "green after soft reset");
      chk(duty_o[3][0], 8'h00, "duty after soft reset");
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      reset_i = 1'b1;
      ce_i = 1'b1;
      bus_i = lmprm_pkg::LMPRM_BUS_FAST;
      open_data_i = '0;
      open_load_i = 1'b0;
      fault_i = 8'h00;
      fails = 0;
      cmp_count = 0;
      tick(20);
      reset_i = 1'b0;
      t_reset();
      t_duty();
      t_spi();
      t_scale();
      t_func();
      end_of_test();
   end
endmodule
`default_nettype wire
